// ### shared/margin_pkg.sv
// Shared constants and types for the supply margining loop
package margin_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25000000;
  localparam int PWM_FREQ_HZ = 62500;
  localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_FREQ_HZ;
  localparam int AVG_WINDOW_MS = 40;
  localparam int AVG_SAMPLES = 8;
  localparam int SAMPLE_CYC = (CLK_HZ / 1000) * AVG_WINDOW_MS / AVG_SAMPLES;
  localparam int TOL_PCT = 1;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DUTY_W = 6;
  localparam int VOUT_W = 12;
  localparam logic [DUTY_W-1:0] DUTY_MIN = 6'h00;
  localparam logic [DUTY_W-1:0] DUTY_MAX = 6'h3f;

  // ----------------------------------------------------------------
  // Command code and field layout of margin_pwm_setup
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_MARGIN_SETUP = 8'he0;
  localparam int SETUP_SLOPE_BIT = 15;
  localparam int SETUP_SEED_MSB = 5;
  localparam int SETUP_SEED_LSB = 0;
  localparam logic [15:0] SETUP_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Operation margin selection
  // ----------------------------------------------------------------
  localparam logic [1:0] OP_NORMAL = 2'h0;
  localparam logic [1:0] OP_MARGIN_HIGH = 2'h1;
  localparam logic [1:0] OP_MARGIN_LOW = 2'h2;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic nota_byte;
    logic nota_word;
    logic mfr_word;
    logic margin_fault;
  } margin_status_t;

endpackage

// ### tb/supply_trim_model.sv
// Behavioural supply whose output follows the filtered PWM trim input
`timescale 1ns/1ps
module supply_trim_model #(
  parameter int BASE = 1000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pwm,
  input wire logic slope_pos,
  output logic [margin_pkg::VOUT_W-1:0] vout
);
  // ----------------------------------------------------------------
  // Trim filter
  // ----------------------------------------------------------------
  // Output settles once per PWM period, so a duty change shows with lag
  int cnt;
  int hi;
  int hi_last;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      hi <= 0;
      hi_last <= 0;
    end else if (cnt == margin_pkg::PWM_PERIOD_CYC - 1) begin
      cnt <= 0;
      hi_last <= hi + int'(pwm);
      hi <= 0;
    end else begin
      cnt <= cnt + 1;
      hi <= hi + int'(pwm);
    end
  end
  assign vout = slope_pos ? 12'(BASE + hi_last) :
                12'(BASE + margin_pkg::PWM_PERIOD_CYC - hi_last);
endmodule

// ### tb/tb.sv
// Self-checking bench for the margining loop
`timescale 1ns/1ps
module tb;
  localparam int S = 100;
  localparam int WIN = 8 * S + 1;
  logic MCLK;
  logic NRST;
  margin_pkg::cmd_req_t CMD;
  logic [15:0] CMD_RDATA;
  logic CMD_RVALID;
  logic ALL_PG;
  logic ALERT_EN;
  logic CLEAR_FAULTS;
  logic slope_pos;
  logic [1:0] OP_MARGIN;
  logic [11:0] VOUT_CODE;
  logic [11:0] VMARGIN_HIGH;
  logic [11:0] VMARGIN_LOW;
  logic PWM_OUT;
  logic PWM_EN;
  logic ALERT_O;
  logic ALERT_OE;
  logic [5:0] DUTY;
  logic [5:0] prev_duty;
  logic prev_en;
  margin_pkg::margin_status_t STATUS;
  int failures;
  int cmp_count;
  int since;

  margin_loop #(.SAMPLE_CYCLES(S)) margin_loop_i (
    .MCLK(MCLK), .NRST(NRST), .CMD(CMD), .CMD_RDATA(CMD_RDATA),
    .CMD_RVALID(CMD_RVALID), .OP_MARGIN(OP_MARGIN), .ALL_PG(ALL_PG),
    .VOUT_CODE(VOUT_CODE), .VMARGIN_HIGH(VMARGIN_HIGH),
    .VMARGIN_LOW(VMARGIN_LOW), .ALERT_EN(ALERT_EN),
    .CLEAR_FAULTS(CLEAR_FAULTS), .PWM_OUT(PWM_OUT), .PWM_EN(PWM_EN),
    .DUTY(DUTY), .STATUS(STATUS), .ALERT_O(ALERT_O), .ALERT_OE(ALERT_OE)
  );
  supply_trim_model supply_trim_model_i (
    .clk(MCLK), .rst_n(NRST), .pwm(PWM_OUT), .slope_pos(slope_pos),
    .vout(VOUT_CODE)
  );

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  // ----------------------------------------------------------------
  // Compare and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Step monitor: every duty change while running is one count,
  // no sooner than a full eight-sample window after the last one
  // ----------------------------------------------------------------
  always @(posedge MCLK) begin
    if (NRST === 1'b1 && PWM_EN === 1'b1 && prev_en === 1'b1) begin
      since++;
      if (DUTY !== prev_duty) begin
        check(16'(int'(DUTY) - int'(prev_duty) + 1) & 16'hfffd, 16'h0000);
        check(16'(since >= 8 * S), 16'h0001);
        since = 0;
      end
    end else begin
      since = 0;
    end
    prev_en = PWM_EN;
    prev_duty = DUTY;
  end

  // ----------------------------------------------------------------
  // Bus and loop helpers
  // ----------------------------------------------------------------
  task automatic cmd(input logic wr, input logic rd, input logic [7:0] code,
                     input logic [15:0] wd);
    @(posedge MCLK);
    CMD <= '{wr: wr, rd: rd, code: code, wdata: wd};
    @(posedge MCLK);
    CMD <= '0;
    #1;
  endtask

  task automatic rd_check(input logic [7:0] code, input logic [15:0] exp);
    cmd(1'b0, 1'b1, code, 16'h0000);
    check(16'(CMD_RVALID), 16'h0001);
    check(CMD_RDATA, exp);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask

  task automatic wait_fault(input int n);
    for (int i = 0; i < n; i++) begin
      wait_cyc(1);
      if (STATUS.margin_fault === 1'b1) begin
        return;
      end
    end
    check(16'h0000, 16'h0001);
    complete_run();
  endtask

  task automatic start(input logic [1:0] op, input logic [15:0] setup,
                       input logic pos);
    int n;
    @(posedge MCLK);
    OP_MARGIN <= margin_pkg::OP_NORMAL;
    ALL_PG <= 1'b0;
    CLEAR_FAULTS <= 1'b1;
    slope_pos <= pos;
    repeat (3) @(posedge MCLK);
    CLEAR_FAULTS <= 1'b0;
    #1 check(16'(PWM_EN), 16'h0000);
    check(16'(STATUS), 16'h0000);
    check(16'(ALERT_OE), 16'h0000);
    cmd(1'b1, 1'b0, margin_pkg::CMD_MARGIN_SETUP, setup);
    @(posedge MCLK);
    OP_MARGIN <= op;
    wait_cyc(6);
    check(16'(PWM_EN), 16'h0000);
    @(posedge MCLK);
    ALL_PG <= 1'b1;
    for (n = 0; n < 5 && PWM_EN !== 1'b1; n++) begin
      wait_cyc(1);
    end
    check(16'(PWM_EN), 16'h0001);
    check(16'(DUTY), 16'(setup[5:0]));
    if (PWM_EN !== 1'b1) begin
      complete_run();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_check(margin_pkg::CMD_MARGIN_SETUP, 16'h0000);
    cmd(1'b1, 1'b0, margin_pkg::CMD_MARGIN_SETUP, 16'hffff);
    rd_check(margin_pkg::CMD_MARGIN_SETUP, 16'h803f);
    wait_cyc(1);
    check(16'(CMD_RVALID), 16'h0000);
    cmd(1'b1, 1'b0, 8'h01, 16'h0000);
    rd_check(margin_pkg::CMD_MARGIN_SETUP, 16'h803f);
    rd_check(8'h01, 16'h0000);
  endtask

  task automatic t_converge();
    int hi;
    @(posedge MCLK);
    VMARGIN_HIGH <= 12'h4b0;
    VMARGIN_LOW <= 12'h000;
    start(margin_pkg::OP_MARGIN_HIGH, 16'hffd4, 1'b1);
    hi = 0;
    repeat (margin_pkg::PWM_PERIOD_CYC) begin
      wait_cyc(1);
      hi += int'(PWM_OUT);
    end
    check(16'(hi), 16'((20 * 400 + 62) / 63));
    wait_cyc(16 * WIN);
    check(16'(STATUS), 16'h0000);
    check(16'(DUTY >= 6'h1e && DUTY <= 6'h21), 16'h0001);
  endtask

  task automatic t_sat_up();
    @(posedge MCLK);
    VMARGIN_HIGH <= 12'hfa0;
    ALERT_EN <= 1'b1;
    start(margin_pkg::OP_MARGIN_HIGH, 16'h803d, 1'b1);
    wait_fault(4 * WIN);
    wait_cyc(2);
    check(16'(DUTY), 16'h003f);
    check(16'(STATUS), 16'h000f);
    check(16'(ALERT_OE), 16'h0001);
    check(16'(ALERT_O), 16'h0000);
    wait_cyc(WIN + 5);
    check(16'(DUTY), 16'h003f);
    check(16'(PWM_EN), 16'h0001);
  endtask

  task automatic t_sat_down();
    @(posedge MCLK);
    ALERT_EN <= 1'b0;
    start(margin_pkg::OP_MARGIN_HIGH, 16'h0002, 1'b0);
    wait_fault(4 * WIN);
    wait_cyc(2);
    check(16'(DUTY), 16'h0000);
    check(16'(STATUS), 16'h000f);
    check(16'(ALERT_OE), 16'h0000);
  endtask

  task automatic t_overshoot();
    @(posedge MCLK);
    VMARGIN_LOW <= 12'h5dc;
    VMARGIN_HIGH <= 12'h000;
    ALERT_EN <= 1'b1;
    start(margin_pkg::OP_MARGIN_LOW, 16'h8028, 1'b1);
    wait_fault(WIN + 10);
    wait_cyc(2);
    check(16'(DUTY), 16'h0029);
    check(16'(ALERT_OE), 16'h0001);
    @(posedge MCLK);
    OP_MARGIN <= margin_pkg::OP_MARGIN_HIGH;
    wait_cyc(2);
    check(16'(PWM_EN), 16'h0000);
    wait_cyc(1);
    check(16'(PWM_EN), 16'h0001);
    check(16'(DUTY), 16'h0028);
    @(posedge MCLK);
    OP_MARGIN <= margin_pkg::OP_NORMAL;
    wait_cyc(3);
    check(16'(PWM_EN), 16'h0000);
  endtask

  task automatic t_reset();
    @(posedge MCLK);
    NRST <= 1'b0;
    wait_cyc(2);
    check(16'(STATUS), 16'h0000);
    check(16'(ALERT_OE), 16'h0000);
    check(16'(DUTY), 16'h0000);
    @(posedge MCLK);
    NRST <= 1'b1;
    rd_check(margin_pkg::CMD_MARGIN_SETUP, 16'h0000);
  endtask

  initial begin
    failures = 0;
    cmp_count = 0;
    since = 0;
    NRST = 1'b0;
    CMD = '0;
    OP_MARGIN = margin_pkg::OP_NORMAL;
    ALL_PG = 1'b0;
    ALERT_EN = 1'b0;
    CLEAR_FAULTS = 1'b0;
    slope_pos = 1'b1;
    VMARGIN_HIGH = 12'h000;
    VMARGIN_LOW = 12'h000;
    repeat (4) @(posedge MCLK);
    NRST <= 1'b1;
    t_regs();
    t_converge();
    t_sat_up();
    t_sat_down();
    t_overshoot();
    t_reset();
    complete_run();
  end
endmodule

// ### verilog/duty_pwm.sv
// Fixed-rate PWM generator with 6-bit duty
`timescale 1ns/1ps
module duty_pwm (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic [margin_pkg::DUTY_W-1:0] duty,
  output logic pwm
);

  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic pwm_r;
  logic pwm_nxt;
  logic [15:0] lhs;
  logic [15:0] rhs;

  // High fraction is duty/63 so code 63 gives a full 100% output
  always_comb begin
    lhs = 16'(cnt_r) * 16'(margin_pkg::DUTY_MAX);
    rhs = 16'(duty) * 16'(margin_pkg::PWM_PERIOD_CYC);
    if (!en || cnt_r == 9'(margin_pkg::PWM_PERIOD_CYC - 1)) begin
      cnt_nxt = 9'h000;
    end else begin
      cnt_nxt = cnt_r + 9'h001;
    end
    pwm_nxt = en && (lhs < rhs);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 9'h000;
      pwm_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pwm_r <= pwm_nxt;
    end
  end

  assign pwm = pwm_r;

  property p_period;
    @(posedge clk) disable iff (!rst_n)
    (en && cnt_r == 9'(margin_pkg::PWM_PERIOD_CYC - 1)) |=> cnt_r == 9'h000;
  endproperty
  a_period: assert property (p_period)
    else $error("PWM period is not 400 cycles");

endmodule

// ### verilog/margin_loop.sv
// Closed-loop margining controller for one supply channel
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Summary of operation
// - The PWM output runs at a fixed 62.5 kHz.
// - Duty is a 6-bit value and one step is one count of it.
// - Margining runs only while operation selects margin high or low.
// - Margining waits until all enabled supplies are power-good.
// - On start the PWM is enabled and loaded with the seed.
// - Each measurement averages eight samples over 40 ms.
// - The target is the high margin level up, the low level down.
// - Outside a 1% band the duty moves one step, else it holds.
// - Duty changes at most once per completed average.
// - Slope bit 15 picks the step direction for a voltage change.
// - Seed bits 5:0 are the first duty for both directions.
// - Setup bits 14:6 always read back as zero.
// - A saturated duty with target unmet sets the fault bits.
// - A margin fault drives alert only when alert is enabled.
// - A first average already past the target is a margin fault.
// ------------------------------------------------------------------
module margin_loop #(
  parameter int SAMPLE_CYCLES = margin_pkg::SAMPLE_CYC
) (
  input wire logic MCLK,
  input wire logic NRST,
  input wire margin_pkg::cmd_req_t CMD,
  output logic [15:0] CMD_RDATA,
  output logic CMD_RVALID,
  input wire logic [1:0] OP_MARGIN,
  input wire logic ALL_PG,
  input wire logic [margin_pkg::VOUT_W-1:0] VOUT_CODE,
  input wire logic [margin_pkg::VOUT_W-1:0] VMARGIN_HIGH,
  input wire logic [margin_pkg::VOUT_W-1:0] VMARGIN_LOW,
  input wire logic ALERT_EN,
  input wire logic CLEAR_FAULTS,
  output logic PWM_OUT,
  output logic PWM_EN,
  output logic [margin_pkg::DUTY_W-1:0] DUTY,
  output margin_pkg::margin_status_t STATUS,
  output logic ALERT_O,
  output logic ALERT_OE
);

  // ----------------------------------------------------------------
  // Loop states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT_PG = 4'h2,
    ST_SEED = 4'h4,
    ST_TRACK = 4'h8
  } loop_st_t;

  loop_st_t st_r;
  loop_st_t st_nxt;
  logic [15:0] setup_r;
  logic [15:0] setup_nxt;
  logic [margin_pkg::DUTY_W-1:0] duty_r;
  logic [margin_pkg::DUTY_W-1:0] duty_nxt;
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic pwm_en_r;
  logic pwm_en_nxt;
  logic fault_r;
  logic fault_nxt;
  logic alert_r;
  logic alert_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  logic [margin_pkg::VOUT_W-1:0] avg;
  logic avg_done;
  logic avg_clr;
  logic [margin_pkg::VOUT_W-1:0] target;
  logic [margin_pkg::VOUT_W-1:0] diff;
  logic [18:0] diff_scaled;
  logic above;
  logic out_band;
  logic duty_up;
  logic at_limit;
  logic want_margin;
  logic fault_set;
  logic slope;
  logic [margin_pkg::DUTY_W-1:0] seed;
  logic reg_hit;

  assign slope = setup_r[margin_pkg::SETUP_SLOPE_BIT];
  assign seed = setup_r[margin_pkg::SETUP_SEED_MSB:margin_pkg::SETUP_SEED_LSB];
  assign want_margin = (OP_MARGIN == margin_pkg::OP_MARGIN_HIGH) ||
                       (OP_MARGIN == margin_pkg::OP_MARGIN_LOW);
  assign reg_hit = (CMD.code == margin_pkg::CMD_MARGIN_SETUP);

  // ----------------------------------------------------------------
  // Measurement path
  // ----------------------------------------------------------------
  // Averager is held clear outside margining so each run starts fresh
  assign avg_clr = !(st_r == ST_SEED || st_r == ST_TRACK);

  vout_avg #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES)
  ) u_avg (
    .clk(MCLK),
    .rst_n(NRST),
    .clr(avg_clr),
    .vout(VOUT_CODE),
    .avg(avg),
    .done(avg_done)
  );

  // ----------------------------------------------------------------
  // Error and step decision
  // ----------------------------------------------------------------
  always_comb begin
    target = (mode_r == margin_pkg::OP_MARGIN_HIGH) ? VMARGIN_HIGH :
             VMARGIN_LOW;
    above = (avg > target);
    diff = above ? (avg - target) : (target - avg);
    // Band test without a divider: diff * 100 > target * TOL_PCT
    diff_scaled = 19'(diff) * 19'h064;
    out_band = diff_scaled > (19'(target) * 19'(margin_pkg::TOL_PCT));
    // Raise the voltage when below target; slope maps that onto duty
    duty_up = slope ? !above : above;
    at_limit = duty_up ? (duty_r == margin_pkg::DUTY_MAX) :
               (duty_r == margin_pkg::DUTY_MIN);
  end

  // ----------------------------------------------------------------
  // Loop sequencing and duty
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    duty_nxt = duty_r;
    mode_nxt = mode_r;
    pwm_en_nxt = pwm_en_r;
    fault_set = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        pwm_en_nxt = 1'b0;
        if (want_margin) begin
          mode_nxt = OP_MARGIN;
          st_nxt = ST_WAIT_PG;
        end
      end
      ST_WAIT_PG: begin
        pwm_en_nxt = 1'b0;
        mode_nxt = OP_MARGIN;
        if (ALL_PG) begin
          duty_nxt = seed;
          pwm_en_nxt = 1'b1;
          st_nxt = ST_SEED;
        end
      end
      ST_SEED, ST_TRACK: begin
        if (avg_done) begin
          if (st_r == ST_SEED && out_band &&
              (mode_r == margin_pkg::OP_MARGIN_HIGH) == above) begin
            fault_set = 1'b1;
          end
          if (out_band) begin
            if (at_limit) begin
              fault_set = 1'b1;
            end else if (duty_up) begin
              duty_nxt = duty_r + 6'h01;
            end else begin
              duty_nxt = duty_r - 6'h01;
            end
          end
          st_nxt = ST_TRACK;
        end
      end
    endcase
    // Leaving margin mode or switching direction restarts the loop
    if (!want_margin) begin
      st_nxt = ST_IDLE;
      pwm_en_nxt = 1'b0;
    end else if (st_r != ST_IDLE && OP_MARGIN != mode_r) begin
      st_nxt = ST_WAIT_PG;
      pwm_en_nxt = 1'b0;
      fault_set = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fault flags and alert
  // ----------------------------------------------------------------
  // A fault arriving with a clear wins, so no event is lost
  always_comb begin
    fault_nxt = fault_set || (fault_r && !CLEAR_FAULTS);
    // A clear in the same cycle makes the set a new event again
    alert_nxt = (fault_set && (!fault_r || CLEAR_FAULTS) && ALERT_EN) ||
                (alert_r && !CLEAR_FAULTS);
  end

  // ----------------------------------------------------------------
  // Command register
  // ----------------------------------------------------------------
  always_comb begin
    setup_nxt = setup_r;
    if (CMD.wr && reg_hit) begin
      setup_nxt = 16'h0000;
      setup_nxt[margin_pkg::SETUP_SLOPE_BIT] =
        CMD.wdata[margin_pkg::SETUP_SLOPE_BIT];
      setup_nxt[margin_pkg::SETUP_SEED_MSB:margin_pkg::SETUP_SEED_LSB] =
        CMD.wdata[margin_pkg::SETUP_SEED_MSB:margin_pkg::SETUP_SEED_LSB];
    end
    rvalid_nxt = CMD.rd;
    // Unused bits are never stored, so they read as zero; other codes too
    rdata_nxt = (CMD.rd && reg_hit) ? setup_r : 16'h0000;
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      st_r <= ST_IDLE;
      setup_r <= margin_pkg::SETUP_RESET;
      duty_r <= margin_pkg::DUTY_MIN;
      mode_r <= margin_pkg::OP_NORMAL;
      pwm_en_r <= 1'b0;
      fault_r <= 1'b0;
      alert_r <= 1'b0;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      setup_r <= setup_nxt;
      duty_r <= duty_nxt;
      mode_r <= mode_nxt;
      pwm_en_r <= pwm_en_nxt;
      fault_r <= fault_nxt;
      alert_r <= alert_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  duty_pwm u_pwm (
    .clk(MCLK),
    .rst_n(NRST),
    .en(pwm_en_r),
    .duty(duty_r),
    .pwm(PWM_OUT)
  );

  assign PWM_EN = pwm_en_r;
  assign DUTY = duty_r;
  assign CMD_RDATA = rdata_r;
  assign CMD_RVALID = rvalid_r;
  assign STATUS = '{nota_byte: fault_r, nota_word: fault_r,
                    mfr_word: fault_r, margin_fault: fault_r};
  // Open-drain alert: pulled low while enabled
  assign ALERT_O = 1'b0;
  assign ALERT_OE = alert_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_seed_load;
    @(posedge MCLK) disable iff (!NRST)
    (st_r == ST_WAIT_PG && ALL_PG && OP_MARGIN == mode_r && want_margin)
      |=> (pwm_en_r && duty_r == $past(seed));
  endproperty
  a_seed_load: assert property (p_seed_load)
    else $error("Seed not loaded when margining started");

  property p_hold_between;
    @(posedge MCLK) disable iff (!NRST)
    (st_r == ST_TRACK && !avg_done) |=> $stable(duty_r);
  endproperty
  a_hold_between: assert property (p_hold_between)
    else $error("Duty changed between averages");

  property p_inband_hold;
    @(posedge MCLK) disable iff (!NRST)
    (st_r == ST_TRACK && avg_done && !out_band) |=> $stable(duty_r);
  endproperty
  a_inband_hold: assert property (p_inband_hold)
    else $error("Duty moved although within tolerance");

  property p_step_up;
    @(posedge MCLK) disable iff (!NRST)
    (st_r == ST_TRACK && want_margin && OP_MARGIN == mode_r && avg_done &&
     out_band && !at_limit && duty_up)
      |=> duty_r == $past(duty_r) + 6'h01;
  endproperty
  a_step_up: assert property (p_step_up)
    else $error("Duty did not step up by one");

  property p_saturate;
    @(posedge MCLK) disable iff (!NRST)
    (st_r == ST_TRACK && want_margin && OP_MARGIN == mode_r && avg_done &&
     out_band && at_limit)
      |=> ($stable(duty_r) && fault_r && STATUS.margin_fault);
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("Saturated duty did not flag a margin fault");

  property p_off_no_pwm;
    @(posedge MCLK) disable iff (!NRST)
    !want_margin |=> (!pwm_en_r ##1 !PWM_OUT);
  endproperty
  a_off_no_pwm: assert property (p_off_no_pwm)
    else $error("PWM active outside margin mode");

  property p_pg_wait;
    @(posedge MCLK) disable iff (!NRST)
    (st_r == ST_WAIT_PG && !ALL_PG) |=> !pwm_en_r;
  endproperty
  a_pg_wait: assert property (p_pg_wait)
    else $error("Margining began before power good");

  property p_alert_gate;
    @(posedge MCLK) disable iff (!NRST)
    (fault_set && !fault_r && !ALERT_EN && !alert_r) |=> !ALERT_OE;
  endproperty
  a_alert_gate: assert property (p_alert_gate)
    else $error("Alert driven while alert disabled");

  property p_rsv_zero;
    @(posedge MCLK) disable iff (!NRST)
    CMD_RVALID |-> CMD_RDATA[14:6] == 9'h000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("Reserved setup bits read nonzero");

endmodule

// ### verilog/vout_avg.sv
// Eight-sample output voltage averager over the feedback window
`timescale 1ns/1ps
module vout_avg #(
  parameter int SAMPLE_CYCLES = margin_pkg::SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic [margin_pkg::VOUT_W-1:0] vout,
  output logic [margin_pkg::VOUT_W-1:0] avg,
  output logic done
);

  localparam int TW = $clog2(SAMPLE_CYCLES + 1);

  logic [TW-1:0] tick_r;
  logic [TW-1:0] tick_nxt;
  logic [2:0] n_r;
  logic [2:0] n_nxt;
  logic [14:0] sum_r;
  logic [14:0] sum_nxt;
  logic [margin_pkg::VOUT_W-1:0] avg_r;
  logic [margin_pkg::VOUT_W-1:0] avg_nxt;
  logic done_r;
  logic done_nxt;
  logic take;

  // One sample per sub-window, the eighth completes the average
  always_comb begin
    take = (tick_r == TW'(SAMPLE_CYCLES - 1));
    tick_nxt = take ? '0 : tick_r + TW'(1);
    n_nxt = n_r;
    sum_nxt = sum_r;
    avg_nxt = avg_r;
    done_nxt = 1'b0;
    if (take) begin
      n_nxt = n_r + 3'h1;
      if (n_r == 3'h7) begin
        avg_nxt = 12'((sum_r + 15'(vout)) >> 3);
        sum_nxt = 15'h0000;
        done_nxt = 1'b1;
      end else begin
        sum_nxt = sum_r + 15'(vout);
      end
    end
    if (clr) begin
      tick_nxt = '0;
      n_nxt = 3'h0;
      sum_nxt = 15'h0000;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= '0;
      n_r <= 3'h0;
      sum_r <= 15'h0000;
      avg_r <= 12'h000;
      done_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      n_r <= n_nxt;
      sum_r <= sum_nxt;
      avg_r <= avg_nxt;
      done_r <= done_nxt;
    end
  end

  assign avg = avg_r;
  assign done = done_r;

  property p_eight;
    @(posedge clk) disable iff (!rst_n)
    done_r |-> (n_r == 3'h0 && $past(n_r) == 3'h7 && $past(take) &&
                !$past(clr));
  endproperty
  a_eight: assert property (p_eight)
    else $error("Average completed before eight samples");

endmodule
